/* logic/lst_params.svh */
// constants for the lvds sync and porch timing register block
// assumes inclusion by the block's design files and its testbench
`ifndef LST_PARAMS_SVH
`define LST_PARAMS_SVH
// register indices; byte address is four times the index
`define LST_IDX_STREAM_MODE 6'h10
`define LST_IDX_LINK_WIDTH 6'h18
`define LST_IDX_B_HSYNC_LO 6'h2e
`define LST_IDX_B_HSYNC_HI 6'h2f
`define LST_IDX_A_VSYNC_LO 6'h30
`define LST_IDX_A_VSYNC_HI 6'h31
`define LST_IDX_B_VSYNC_LO 6'h32
`define LST_IDX_B_VSYNC_HI 6'h33
`define LST_IDX_A_LINE_GAP 6'h34
`define LST_IDX_B_LINE_GAP 6'h35
`define LST_IDX_A_FRAME_GAP 6'h36
`define LST_IDX_STATUS 6'h3f
// slot numbers of the writable registers
`define LST_NUM_SLOTS 11
`define LST_SLOT_MODE 0
`define LST_SLOT_WIDTH 1
`define LST_SLOT_BHS_LO 2
`define LST_SLOT_BHS_HI 3
`define LST_SLOT_AVS_LO 4
`define LST_SLOT_AVS_HI 5
`define LST_SLOT_BVS_LO 6
`define LST_SLOT_BVS_HI 7
`define LST_SLOT_ALG 8
`define LST_SLOT_BLG 9
`define LST_SLOT_AFG 10
`define LST_NO_SLOT 4'hf
// field positions and masks
`define LST_SINGLE_BIT 4
`define LST_MODE_LSB 5
`define LST_MODE_MSB 6
`define LST_MASK_FULL 8'hff
`define LST_MASK_UPPER 8'h0f
`define LST_MASK_SINGLE 8'h10
`define LST_MASK_MODE 8'h60
`define LST_CHMODE_SPLIT 2'h2
`define LST_REG_RESET 8'h00
`define LST_RESP_OKAY 2'h0
`define LST_RESP_SLVERR 2'h2
`define LST_BYTE_SHIFT 8
`endif

/* logic/lst_pkg.sv */
// types shared by the lvds sync and porch timing register block
// assumes lst_params.svh supplies the numeric constants
package lst_pkg;
  typedef enum logic [1:0] {
    LST_SINGLE = 2'h0,
    LST_SHARED = 2'h1,
    LST_SPLIT = 2'h2
  } lst_stream_e;
  typedef enum logic {
    LST_W_IDLE = 1'h0,
    LST_W_RESP = 1'h1
  } lst_wr_state_e;
  typedef enum logic {
    LST_R_IDLE = 1'h0,
    LST_R_BUSY = 1'h1
  } lst_rd_state_e;
  // timing handed to one link's output timing generator
  typedef struct packed {
    logic [9:0] vsync_len;
    logic [7:0] line_gap;
    logic [7:0] frame_gap;
  } lst_chan_timing_s;
endpackage : lst_pkg

/* logic/lst_byte_reg.sv */
// one byte-wide software register with a mask of implemented bits
// assumes write enable and data come from the bus slave on aclk
`timescale 1ns/10ps
`include "lst_params.svh"
module lst_byte_reg
  import lst_pkg::*;
#(
  parameter logic [7:0] MASK = `LST_MASK_FULL
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [7:0] wbyte,
  output logic [7:0] q
);
  logic [7:0] q_reg;
  logic [7:0] q_next;
  // unimplemented bits are never stored, so they read as zero
  always_comb begin
    q_next = we ? (wbyte & MASK) : q_reg;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= `LST_REG_RESET;
    end else begin
      q_reg <= q_next;
    end
  end
  assign q = q_reg;
endmodule : lst_byte_reg

/* logic/lst_pin_sync.sv */
// three-stage synchroniser for a level arriving from a pin
// assumes the pin is asynchronous to aclk
`timescale 1ns/10ps
`include "lst_params.svh"
module lst_pin_sync
  import lst_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic level
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;
  // first stage feeds only the second; change counts once 2 and 3 agree
  always_comb begin
    stage_next = {stage_reg[1:0], pin};
    level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_reg <= 3'h0;
      level_reg <= 1'h0;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end
  assign level = level_reg;
endmodule : lst_pin_sync

/* logic/lst_timing_regs.sv */
// sync width and back porch registers for lvds links a and b,
// with an axi4-lite slave and the resolved per-link timing outputs
// assumes one aclk domain; test_pattern_pin may be asynchronous
//
// Summary of operation
// [R1] - link a vsync length: 10 bits, low byte plus two bits of next register
// [R2] - link a vsync serves a alone in single link, both links when shared
// [R3] - link b vsync length, 10 bits split, used only in split channel mode
// [R4] - link b hsync upper bits in low nibble, effective only in split mode
// [R5] - link a 8-bit back porch in pixel clocks, shared by b when shared
// [R6] - link b own 8-bit back porch, used only in split mode
// [R7] - link a 8-bit vertical back porch, used only for the test pattern
// [R8] - dual link with channel mode 10 gives two independent streams
// [R9] - link b hsync low byte in its own register, joined with upper bits
// [R10] - reserved upper nibble bits read zero and never affect timing
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`include "lst_params.svh"
module lst_timing_regs
  import lst_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic test_pattern_pin,
  output lst_stream_e stream_mode,
  output logic link_b_on,
  output lst_chan_timing_s link_a_timing,
  output lst_chan_timing_s link_b_timing,
  output logic [9:0] link_b_hsync_len
);
  // the decode relies on the index field sitting in bits 7..2
  if (ADDR_W < 8) begin : g_addr_check
    $error("lst_timing_regs: ADDR_W must be at least 8");
  end

  // address to writable slot; status and holes give no slot
  function automatic logic [3:0] slot_of(input logic [ADDR_W-1:0] a);
    logic [5:0] idx;
    idx = a[7:2];
    if ((a >> `LST_BYTE_SHIFT) != '0) begin
      return `LST_NO_SLOT;
    end
    case (idx)
      `LST_IDX_STREAM_MODE: return 4'(`LST_SLOT_MODE);
      `LST_IDX_LINK_WIDTH: return 4'(`LST_SLOT_WIDTH);
      `LST_IDX_B_HSYNC_LO: return 4'(`LST_SLOT_BHS_LO);
      `LST_IDX_B_HSYNC_HI: return 4'(`LST_SLOT_BHS_HI);
      `LST_IDX_A_VSYNC_LO: return 4'(`LST_SLOT_AVS_LO);
      `LST_IDX_A_VSYNC_HI: return 4'(`LST_SLOT_AVS_HI);
      `LST_IDX_B_VSYNC_LO: return 4'(`LST_SLOT_BVS_LO);
      `LST_IDX_B_VSYNC_HI: return 4'(`LST_SLOT_BVS_HI);
      `LST_IDX_A_LINE_GAP: return 4'(`LST_SLOT_ALG);
      `LST_IDX_B_LINE_GAP: return 4'(`LST_SLOT_BLG);
      `LST_IDX_A_FRAME_GAP: return 4'(`LST_SLOT_AFG);
      default: return `LST_NO_SLOT;
    endcase
  endfunction : slot_of

  // implemented bits of each slot
  function automatic logic [7:0] slot_mask(input int s);
    case (s)
      `LST_SLOT_MODE: return `LST_MASK_MODE;
      `LST_SLOT_WIDTH: return `LST_MASK_SINGLE;
      `LST_SLOT_BHS_HI, `LST_SLOT_AVS_HI, `LST_SLOT_BVS_HI: return `LST_MASK_UPPER; // [R10]
      default: return `LST_MASK_FULL;
    endcase
  endfunction : slot_mask

  logic [`LST_NUM_SLOTS-1:0][7:0] slot_q;
  logic wr_fire;
  logic tp_on;
  lst_wr_state_e wst_reg, wst_next;
  lst_rd_state_e rst_reg, rst_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [ADDR_W-1:0] waddr_reg, waddr_next;
  logic [7:0] wbyte_reg, wbyte_next;
  logic wstrb0_reg, wstrb0_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic aw_take, w_take, ar_take;
  logic [3:0] wslot, rslot;
  assign aw_take = awvalid & awready_reg;
  assign w_take = wvalid & wready_reg;
  assign ar_take = arvalid & arready_reg;
  assign wslot = slot_of(waddr_next);
  assign rslot = slot_of(araddr);
  // test pattern enable arrives from a pin
  lst_pin_sync u_tp_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(test_pattern_pin),
    .level(tp_on)
  );
  // one byte register per slot; data sits in byte lane 0 only
  for (genvar g = 0; g < `LST_NUM_SLOTS; g++) begin : g_slot
    lst_byte_reg #(
      .MASK(slot_mask(g))
    ) u_reg (
      .aclk(aclk),
      .aresetn(aresetn),
      .we(wr_fire && (wslot == 4'(g)) && wstrb0_next),
      .wbyte(wbyte_next),
      .q(slot_q[g])
    );
  end
  // write channel: address and data taken in either order
  always_comb begin
    aw_have_next = aw_have_reg | aw_take;
    w_have_next = w_have_reg | w_take;
    waddr_next = aw_take ? awaddr : waddr_reg;
    wbyte_next = w_take ? wdata[7:0] : wbyte_reg;
    wstrb0_next = w_take ? wstrb[0] : wstrb0_reg;
    wst_next = wst_reg;
    bresp_next = bresp_reg;
    wr_fire = 1'h0;
    case (wst_reg)
      LST_W_IDLE: begin
        if (aw_have_next && w_have_next) begin
          wr_fire = 1'h1;
          wst_next = LST_W_RESP;
          aw_have_next = 1'h0;
          w_have_next = 1'h0;
          bresp_next = (wslot == `LST_NO_SLOT) ? `LST_RESP_SLVERR : `LST_RESP_OKAY;
        end
      end
      LST_W_RESP: begin
        if (bready) begin
          wst_next = LST_W_IDLE;
        end
      end
      default: wst_next = LST_W_IDLE;
    endcase
    // no new address or data while a response is pending
    awready_next = (wst_next == LST_W_IDLE) && !aw_have_next;
    wready_next = (wst_next == LST_W_IDLE) && !w_have_next;
    bvalid_next = (wst_next == LST_W_RESP);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_reg <= LST_W_IDLE;
      aw_have_reg <= 1'h0;
      w_have_reg <= 1'h0;
      waddr_reg <= '0;
      wbyte_reg <= 8'h00;
      wstrb0_reg <= 1'h0;
      awready_reg <= 1'h0;
      wready_reg <= 1'h0;
      bvalid_reg <= 1'h0;
      bresp_reg <= `LST_RESP_OKAY;
    end else begin
      wst_reg <= wst_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      waddr_reg <= waddr_next;
      wbyte_reg <= wbyte_next;
      wstrb0_reg <= wstrb0_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end
  // read channel: data is ready one edge after the address is taken
  always_comb begin
    rst_next = rst_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rst_reg)
      LST_R_IDLE: begin
        if (ar_take) begin
          rst_next = LST_R_BUSY;
          rdata_next = 32'h0;
          rresp_next = `LST_RESP_OKAY;
          if (rslot != `LST_NO_SLOT) begin
            for (int i = 0; i < `LST_NUM_SLOTS; i++) begin
              if (rslot == 4'(i)) begin
                rdata_next = {24'h0, slot_q[i]}; // [R10]
              end
            end
          end else if ((araddr[7:2] == `LST_IDX_STATUS) && ((araddr >> `LST_BYTE_SHIFT) == '0)) begin
            rdata_next = {29'h0, tp_on, stream_mode};
          end else begin
            rresp_next = `LST_RESP_SLVERR;
          end
        end
      end
      LST_R_BUSY: begin
        if (rready) begin
          rst_next = LST_R_IDLE;
        end
      end
      default: rst_next = LST_R_IDLE;
    endcase
    arready_next = (rst_next == LST_R_IDLE);
    rvalid_next = (rst_next == LST_R_BUSY);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_reg <= LST_R_IDLE;
      rdata_reg <= 32'h0;
      rresp_reg <= `LST_RESP_OKAY;
      arready_reg <= 1'h0;
      rvalid_reg <= 1'h0;
    end else begin
      rst_reg <= rst_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // resolve which values reach each link for the selected mode
  lst_stream_e mode_reg, mode_next;
  lst_chan_timing_s a_reg, a_next, b_reg, b_next;
  logic b_on_reg, b_on_next;
  logic [9:0] b_hs_reg, b_hs_next;
  always_comb begin
    if (slot_q[`LST_SLOT_WIDTH][`LST_SINGLE_BIT]) begin
      mode_next = LST_SINGLE;
    end else if (slot_q[`LST_SLOT_MODE][`LST_MODE_MSB:`LST_MODE_LSB] == `LST_CHMODE_SPLIT) begin
      mode_next = LST_SPLIT; // [R8]
    end else begin
      mode_next = LST_SHARED;
    end
    // only the two low bits of each upper register form the value
    a_next.vsync_len = {slot_q[`LST_SLOT_AVS_HI][1:0], slot_q[`LST_SLOT_AVS_LO]}; // [R1]
    a_next.line_gap = slot_q[`LST_SLOT_ALG]; // [R5]
    a_next.frame_gap = tp_on ? slot_q[`LST_SLOT_AFG] : 8'h00; // [R7]
    b_next = '0;
    b_on_next = 1'h0;
    b_hs_next = 10'h0;
    case (mode_next)
      LST_SINGLE: b_on_next = 1'h0; // [R2]
      LST_SHARED: begin
        b_next = a_next; // [R2] [R5] [R7]
        b_on_next = 1'h1;
      end
      LST_SPLIT: begin
        b_next.vsync_len = {slot_q[`LST_SLOT_BVS_HI][1:0], slot_q[`LST_SLOT_BVS_LO]}; // [R3]
        b_next.line_gap = slot_q[`LST_SLOT_BLG]; // [R6]
        b_hs_next = {slot_q[`LST_SLOT_BHS_HI][1:0], slot_q[`LST_SLOT_BHS_LO]}; // [R4] [R9]
        b_on_next = 1'h1;
      end
      default: b_on_next = 1'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= LST_SHARED;
      a_reg <= '0;
      b_reg <= '0;
      b_on_reg <= 1'h1; // zero registers decode as shared, so b is on
      b_hs_reg <= 10'h0;
    end else begin
      mode_reg <= mode_next;
      a_reg <= a_next;
      b_reg <= b_next;
      b_on_reg <= b_on_next;
      b_hs_reg <= b_hs_next;
    end
  end
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign stream_mode = mode_reg;
  assign link_b_on = b_on_reg;
  assign link_a_timing = a_reg;
  assign link_b_timing = b_reg;
  assign link_b_hsync_len = b_hs_reg;
  // checks on resolved timing and bus answers
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_vsync_join_a: assert property (1'b1 |=> link_a_timing.vsync_len ==
    $past({slot_q[`LST_SLOT_AVS_HI][1:0], slot_q[`LST_SLOT_AVS_LO]}))
    else $error("link a vsync length not joined from its two registers"); // [R1]
  shared_follow_a: assert property (stream_mode == LST_SHARED |->
    link_b_on && link_b_timing == link_a_timing)
    else $error("link b does not follow link a in shared mode"); // [R2]
  single_b_off_a: assert property (stream_mode == LST_SINGLE |-> !link_b_on)
    else $error("link b active in single link mode"); // [R2]
  b_vsync_split_a: assert property (mode_next == LST_SPLIT |=> link_b_timing.vsync_len ==
    $past({slot_q[`LST_SLOT_BVS_HI][1:0], slot_q[`LST_SLOT_BVS_LO]}))
    else $error("link b vsync length wrong in split mode"); // [R3]
  b_hsync_gate_a: assert property (stream_mode != LST_SPLIT |-> link_b_hsync_len == 10'h0)
    else $error("link b hsync width used outside split mode"); // [R4]
  b_hsync_join_a: assert property (mode_next == LST_SPLIT |=> link_b_hsync_len ==
    $past({slot_q[`LST_SLOT_BHS_HI][1:0], slot_q[`LST_SLOT_BHS_LO]}))
    else $error("link b hsync width not joined from its registers"); // [R9]
  a_line_gap_a: assert property (1'b1 |=> link_a_timing.line_gap ==
    $past(slot_q[`LST_SLOT_ALG]))
    else $error("link a back porch not taken from its register"); // [R5]
  b_line_gap_a: assert property (mode_next == LST_SPLIT |=> link_b_timing.line_gap ==
    $past(slot_q[`LST_SLOT_BLG]))
    else $error("link b back porch wrong in split mode"); // [R6]
  frame_gap_gate_a: assert property (!tp_on |=> link_a_timing.frame_gap == 8'h00)
    else $error("vertical back porch applied without test pattern"); // [R7]
  split_select_a: assert property (!slot_q[`LST_SLOT_WIDTH][`LST_SINGLE_BIT] &&
    slot_q[`LST_SLOT_MODE][`LST_MODE_MSB:`LST_MODE_LSB] == `LST_CHMODE_SPLIT |=>
    stream_mode == LST_SPLIT && link_b_on)
    else $error("split channel mode not selected"); // [R8]
  upper_read_zero_a: assert property (ar_take && rslot == 4'(`LST_SLOT_AVS_HI) |=>
    rvalid && rdata[31:4] == 28'h0)
    else $error("reserved bits of upper register read nonzero"); // [R10]
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");
  split_seen_c: cover property (stream_mode == LST_SPLIT ##1 link_b_hsync_len != 10'h0);
  write_done_c: cover property (wr_fire ##[1:4] bvalid && bready);
  read_done_c: cover property (ar_take ##1 rvalid && rready);
  tp_gap_c: cover property (tp_on && link_a_timing.frame_gap != 8'h00);
endmodule : lst_timing_regs

/* testbench/lst_panel_model.sv */
// panel-side model: owns the test pattern strap pin of the bridge
// assumes the bench asks for the pattern through tp_req on aclk
`timescale 1ns/10ps
module lst_panel_model
  import lst_pkg::*;
(
  input wire logic aclk,
  input wire logic tp_req,
  output logic test_pattern_pin
);
  // strap sits low by its pull-down until asked
  initial test_pattern_pin = 1'b0;
  // pin follows the request one edge later; the bridge resynchronises it
  always @(posedge aclk) begin
    test_pattern_pin <= tp_req;
  end
endmodule : lst_panel_model

/* testbench/lst_timing_regs_tb.sv */
// self-checking bench for the sync and porch timing registers
// assumes the design and lst_panel_model compile before it
`timescale 1ns/10ps
`include "lst_params.svh"
module lst_timing_regs_tb
  import lst_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, tp_req = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, link_b_on, test_pattern_pin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] link_b_hsync_len;
  lst_stream_e stream_mode;
  lst_chan_timing_s link_a_timing, link_b_timing;
  int failures = 0;
  int n_checks = 0;
  logic [5:0] idxs [11] = '{`LST_IDX_STREAM_MODE, `LST_IDX_LINK_WIDTH, `LST_IDX_B_HSYNC_LO,
    `LST_IDX_B_HSYNC_HI, `LST_IDX_A_VSYNC_LO, `LST_IDX_A_VSYNC_HI, `LST_IDX_B_VSYNC_LO,
    `LST_IDX_B_VSYNC_HI, `LST_IDX_A_LINE_GAP, `LST_IDX_B_LINE_GAP, `LST_IDX_A_FRAME_GAP};

  lst_timing_regs lst_timing_regs_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .test_pattern_pin(test_pattern_pin), .stream_mode(stream_mode),
    .link_b_on(link_b_on), .link_a_timing(link_a_timing), .link_b_timing(link_b_timing),
    .link_b_hsync_len(link_b_hsync_len));
  lst_panel_model lst_panel_model_inst (.aclk(aclk), .tp_req(tp_req),
    .test_pattern_pin(test_pattern_pin));

  // 100 MHz clock
  always #5 aclk = ~aclk;

  task summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // write: address and data offered together, each dropped once taken
  task wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 50);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "write response");
    if (n >= 50) failures++;
    // an edge passes so the next call never re-raises bready in this step
    tick(1);
  endtask : wr

  task rd(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 50);
    rready <= 1'b0;
    chk(rdata, {24'h0, exp}, "read data");
    chk({30'h0, rresp}, {30'h0, er}, "read response");
    if (n >= 50) failures++;
    // an edge passes so the next call never re-raises rready in this step
    tick(1);
  endtask : rd

  // every writable register clears to zero; zeros decode as shared dual link
  task t_reset;
    foreach (idxs[i]) rd(idxs[i], 8'h00, `LST_RESP_OKAY);
    chk({30'h0, stream_mode}, {30'h0, LST_SHARED}, "reset mode");
    chk({31'h0, link_b_on}, 32'h1, "reset link b");
  endtask : t_reset

  // shared: link b follows link a, its own registers are ignored
  task t_shared;
    logic [1:0] modes [3] = '{2'h0, 2'h1, 2'h3};
    wr(`LST_IDX_A_VSYNC_LO, 8'ha5, 4'h1, `LST_RESP_OKAY);
    wr(`LST_IDX_A_VSYNC_HI, 8'hf3, 4'h1, `LST_RESP_OKAY);
    rd(`LST_IDX_A_VSYNC_HI, 8'h03, `LST_RESP_OKAY);
    wr(`LST_IDX_A_LINE_GAP, 8'h5a, 4'h1, `LST_RESP_OKAY);
    wr(`LST_IDX_B_LINE_GAP, 8'h22, 4'h1, `LST_RESP_OKAY);
    wr(`LST_IDX_B_VSYNC_LO, 8'h11, 4'h1, `LST_RESP_OKAY);
    wr(`LST_IDX_B_HSYNC_LO, 8'h3c, 4'h1, `LST_RESP_OKAY);
    foreach (modes[i]) begin
      wr(`LST_IDX_STREAM_MODE, {1'b0, modes[i], 5'h0}, 4'h1, `LST_RESP_OKAY);
      tick(3);
      chk({30'h0, stream_mode}, {30'h0, LST_SHARED}, "shared mode");
      chk({6'h0, link_a_timing}, {6'h0, 10'h3a5, 8'h5a, 8'h00}, "a shared");
      chk({6'h0, link_b_timing}, {6'h0, 10'h3a5, 8'h5a, 8'h00}, "b shared");
      chk({22'h0, link_b_hsync_len}, 32'h0, "b hsync shared");
    end
  endtask : t_shared

  // single link: only link a carries timing
  task t_single;
    wr(`LST_IDX_LINK_WIDTH, `LST_MASK_SINGLE, 4'h1, `LST_RESP_OKAY);
    tick(3);
    chk({30'h0, stream_mode}, {30'h0, LST_SINGLE}, "single mode");
    chk({31'h0, link_b_on}, 32'h0, "link b off");
    chk({6'h0, link_b_timing}, 32'h0, "b single");
    chk({6'h0, link_a_timing}, {6'h0, 10'h3a5, 8'h5a, 8'h00}, "a single");
    wr(`LST_IDX_LINK_WIDTH, 8'h00, 4'h1, `LST_RESP_OKAY);
  endtask : t_single

  // split: two independent streams, link b uses its own values
  task t_split;
    wr(`LST_IDX_STREAM_MODE, 8'h40, 4'h1, `LST_RESP_OKAY);
    wr(`LST_IDX_B_HSYNC_HI, 8'hfe, 4'h1, `LST_RESP_OKAY);
    rd(`LST_IDX_B_HSYNC_HI, 8'h0e, `LST_RESP_OKAY);
    wr(`LST_IDX_B_VSYNC_HI, 8'h01, 4'h1, `LST_RESP_OKAY);
    tick(3);
    chk({30'h0, stream_mode}, {30'h0, LST_SPLIT}, "split mode");
    chk({31'h0, link_b_on}, 32'h1, "link b on");
    chk({6'h0, link_b_timing}, {6'h0, 10'h111, 8'h22, 8'h00}, "b split");
    chk({6'h0, link_a_timing}, {6'h0, 10'h3a5, 8'h5a, 8'h00}, "a split");
    chk({22'h0, link_b_hsync_len}, 32'h23c, "b hsync split");
  endtask : t_split

  // vertical porch reaches link a only while the test pattern runs
  task t_pattern;
    wr(`LST_IDX_A_FRAME_GAP, 8'h77, 4'h1, `LST_RESP_OKAY);
    tick(3);
    chk({24'h0, link_a_timing.frame_gap}, 32'h0, "porch without pattern");
    tp_req <= 1'b1;
    tick(10);
    chk({24'h0, link_a_timing.frame_gap}, 32'h77, "porch with pattern");
    rd(`LST_IDX_STATUS, 8'h06, `LST_RESP_OKAY);
    tp_req <= 1'b0;
    tick(10);
    chk({24'h0, link_a_timing.frame_gap}, 32'h0, "porch after pattern");
  endtask : t_pattern

  // refused and ignored accesses leave the registers alone
  task t_bus;
    wr(6'h20, 8'h5a, 4'h1, `LST_RESP_SLVERR);
    rd(6'h20, 8'h00, `LST_RESP_SLVERR);
    wr(`LST_IDX_STATUS, 8'hff, 4'h1, `LST_RESP_SLVERR);
    wr(`LST_IDX_A_LINE_GAP, 8'h99, 4'h0, `LST_RESP_OKAY);
    rd(`LST_IDX_A_LINE_GAP, 8'h5a, `LST_RESP_OKAY);
  endtask : t_bus

  // reset held five cycles, then the scenarios in turn
  initial begin
    tick(5);
    aresetn <= 1'b1;
    tick(1);
    t_reset;
    t_shared;
    t_single;
    t_split;
    t_pattern;
    t_bus;
    summarize;
  end

  // watchdog: the run needs well under 2000 cycles
  initial begin
    #100000;
    failures++;
    summarize;
  end
endmodule : lst_timing_regs_tb
